// file: hw/ulc_pkg.sv
// shared constants and types for the usb link configuration fields
package ulc_pkg;

  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  // byte address of the configuration word on the register port
  localparam logic [7:0]  CFG_WORD_OFFSET = 8'h80;

  // field positions inside the configuration word
  localparam int unsigned SPEED_LSB       = 13;
  localparam int unsigned SPEED_MSB       = 15;
  localparam int unsigned OVERLAP_BIT     = 12;
  localparam int unsigned SHORT_U2_BIT    = 11;
  localparam int unsigned TX_RST_BIT      = 10;
  localparam int unsigned RX_RST_BIT      = 9;
  localparam int unsigned L1_SLEEP_BIT    = 8;
  localparam int unsigned EMPTY_REPLY_BIT = 6;

  // connect speed codes
  localparam logic [2:0] SPEED_SUPER = 3'h4;
  localparam logic [2:0] SPEED_HIGH  = 3'h0;
  localparam logic [2:0] SPEED_FULL  = 3'h1;

  // values after reset and fallback defaults when no image is present
  localparam logic [2:0] SPEED_RESET       = SPEED_SUPER;
  localparam logic       OVERLAP_FALLBACK  = 1'h0;
  localparam logic       SHORT_U2_FALLBACK = 1'h0;
  localparam logic       L1_SLEEP_FALLBACK = 1'h1;
  localparam logic       EMPTY_REPLY_RESET = 1'h0;
  localparam logic       SC_BIT_RESET      = 1'h0;

  // timing
  localparam int unsigned CLK_MHZ         = 40;
  localparam int unsigned LFPS_SHORT_NS   = 248;
  localparam int unsigned LFPS_LONG_US    = 8;
  // least times: round up to whole cycles
  localparam int unsigned LFPS_SHORT_CYC  = (LFPS_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LFPS_LONG_CYC   = LFPS_LONG_US * CLK_MHZ;
  localparam int unsigned LFPS_CNT_W      = 10;
  // length of a sub-block reset pulse
  localparam logic [3:0]  SUBRST_CYCLES   = 4'h4;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_WAIT = 2'b10
  } ulc_hs_state_t;

endpackage

// file: hw/ulc_config_fields.sv
// usb link configuration word, bits 15:6, with the logic those bits steer
// What this block does
// - a three-bit read/write connect speed at bits 15:13 resets to 100b; 100 super, 000 high, 001 full speed.
// - with bit 12 set, a remote exit from U1/U2/U3 waits for partner LFPS or TS1/TS2 before the handshake completes.
// - with bit 12 clear, a remote exit completes without looking for partner LFPS overlap.
// - with bit 11 set, LFPS lasting 248 ns is a valid U2 exit.
// - with bit 11 clear, U2 exit needs 8 us of LFPS and shorter glitches leave the link in U2.
// - writing 1 to bit 10 resets the bulk-in transmitter; the bit clears itself and resets to 0.
// - writing 1 to bit 9 resets the bulk-out receiver; the bit clears itself and resets to 0.
// - bit 8 enables UTMI sleep and L1 suspend towards the PHY in L1.
// - bit 6 picks the reply to IN tokens on an empty receive FIFO: 0 zero-length packet, 1 NAK; resets to 0.
// - speed, overlap check, U2 filter and L1 sleep fields keep their value through USB and lite resets while reset protection is on.
// - overlap check and U2 filter defaults come from EEPROM, else OTP, else 0, and USB or lite reset restores them.
// - L1 sleep enable default comes from EEPROM, else OTP, else 1, and USB or lite reset restores it.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module ulc_config_fields
  import ulc_pkg::*;
(
  input  wire logic                     core_clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     ce_i,
  // register port
  input  wire logic [ulc_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [ulc_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  output logic      [ulc_pkg::DATA_W-1:0] reg_rdata_o,
  // image loader and resets
  input  wire logic                     image_load_i,
  input  wire logic                     eeprom_present_i,
  input  wire logic                     otp_present_i,
  input  wire logic [2:0]               eeprom_flags_i,
  input  wire logic [2:0]               otp_flags_i,
  input  wire logic                     usb_reset_i,
  input  wire logic                     lite_soft_reset_i,
  input  wire logic                     rst_protect_i,
  // superspeed low-power exit
  input  wire logic                     remote_exit_start_i,
  input  wire logic                     partner_lfps_i,
  input  wire logic                     training_seen_i,
  output logic                          exit_handshake_done_o,
  input  wire logic                     in_u2_i,
  input  wire logic                     lfps_detect_i,
  output logic                          u2_exit_o,
  // sub-block resets
  output logic                          bulk_in_transmitter_reset_o,
  output logic                          bulk_out_receiver_reset_o,
  // l1 sleep
  input  wire logic                     l1_sleep_req_i,
  output logic                          utmi_sleep_o,
  // empty-fifo reply
  input  wire logic                     in_token_i,
  input  wire logic                     rx_fifo_empty_i,
  output logic                          send_zlp_o,
  output logic                          send_nak_o,
  output logic      [2:0]               connect_speed_select_o
);
  import ulc_pkg::*;

  typedef struct packed {
    // software-visible fields
    logic [2:0]            speed;
    logic                  overlap;
    logic                  short_u2;
    logic                  l1_sleep;
    logic                  empty_nak;

    // defaults from the last image load, restored by usb or lite reset
    logic                  overlap_dflt;
    logic                  short_u2_dflt;
    logic                  l1_sleep_dflt;

    // self-clearing sub-block resets and their countdowns
    logic                  tx_rst;
    logic [3:0]            tx_cnt;
    logic                  rx_rst;
    logic [3:0]            rx_cnt;

    // u2 exit filter: synchroniser and burst length
    logic [1:0]            lfps_sync;
    logic [LFPS_CNT_W-1:0] lfps_cnt;

    // remote exit handshake
    ulc_hs_state_t         hs;
    logic                  hs_done;

    // registered outputs
    logic                  u2_exit;
    logic                  utmi_sleep;
    logic                  send_zlp;
    logic                  send_nak;
    logic [DATA_W-1:0]     rdata;
  } ulc_state_t;

  // st holds every flop; next_st is its value for the coming edge
  ulc_state_t st;
  ulc_state_t next_st;

  // combinational helpers, none of them state
  logic                  hit;
  logic                  restore;
  logic [2:0]            img;
  logic [LFPS_CNT_W-1:0] lfps_thr;
  logic [DATA_W-1:0]     word;

  always_comb begin
    // only the one mapped word answers; other addresses ignore writes and read 0
    hit      = (reg_addr_i == CFG_WORD_OFFSET);

    // usb and lite resets restore protected fields only with protection off
    restore  = (usb_reset_i | lite_soft_reset_i) & ~rst_protect_i;
    // image bits: [0] overlap check, [1] short u2 filter, [2] l1 sleep
    if (eeprom_present_i) begin
      img = eeprom_flags_i;
    end else if (otp_present_i) begin
      img = otp_flags_i;
    end else begin
      img = {L1_SLEEP_FALLBACK, SHORT_U2_FALLBACK, OVERLAP_FALLBACK};
    end
    // the long filter trades exit latency for staying in U2 through short host glitches
    if (st.short_u2) begin
      lfps_thr = LFPS_CNT_W'(LFPS_SHORT_CYC);
    end else begin
      lfps_thr = LFPS_CNT_W'(LFPS_LONG_CYC);
    end

    // bits 31:16, 7 and 5:0 read as zero
    word                             = '0;
    word[SPEED_MSB:SPEED_LSB]        = st.speed;
    word[OVERLAP_BIT]                = st.overlap;
    word[SHORT_U2_BIT]               = st.short_u2;
    word[TX_RST_BIT]                 = st.tx_rst;
    word[RX_RST_BIT]                 = st.rx_rst;
    word[L1_SLEEP_BIT]               = st.l1_sleep;
    word[EMPTY_REPLY_BIT]            = st.empty_nak;

    next_st = st;

    // loaded image defaults, used again on every usb or lite reset while protection is off
    // without a restoring reset in the same cycle, the image also lands at once in the live fields, below
    if (image_load_i) begin
      next_st.overlap_dflt  = img[0];
      next_st.short_u2_dflt = img[1];
      next_st.l1_sleep_dflt = img[2];
    end

    // protected fields: a reset restores them only while protection is off
    if (restore) begin
      next_st.speed    = SPEED_RESET;
      next_st.overlap  = st.overlap_dflt;
      next_st.short_u2 = st.short_u2_dflt;
      next_st.l1_sleep = st.l1_sleep_dflt;
    end else if (image_load_i) begin
      next_st.overlap  = img[0];
      next_st.short_u2 = img[1];
      next_st.l1_sleep = img[2];
    end

    // sub-block reset countdown; hardware ends the pulse
    // a second write of 1 while the count runs starts it again from the top
    if (st.tx_cnt != 4'h0) begin
      next_st.tx_cnt = st.tx_cnt - 4'h1;
    end
    if (st.rx_cnt != 4'h0) begin
      next_st.rx_cnt = st.rx_cnt - 4'h1;
    end

    // the bulk-in reply bit is not protected, any usb or lite reset clears it
    if (usb_reset_i | lite_soft_reset_i) begin
      next_st.empty_nak = EMPTY_REPLY_RESET;
    end

    // a software write lands after the resets, so a write in the same cycle wins
    // reset protection guards against usb and lite resets only, never software
    if (reg_wr_i && hit) begin
      next_st.speed     = reg_wdata_i[SPEED_MSB:SPEED_LSB];
      next_st.overlap   = reg_wdata_i[OVERLAP_BIT];
      next_st.short_u2  = reg_wdata_i[SHORT_U2_BIT];
      next_st.l1_sleep  = reg_wdata_i[L1_SLEEP_BIT];
      next_st.empty_nak = reg_wdata_i[EMPTY_REPLY_BIT];
      // writing 0 to a self-clearing bit leaves it alone
      if (reg_wdata_i[TX_RST_BIT]) begin
        next_st.tx_cnt = SUBRST_CYCLES;
      end
      if (reg_wdata_i[RX_RST_BIT]) begin
        next_st.rx_cnt = SUBRST_CYCLES;
      end
    end
    next_st.tx_rst = (next_st.tx_cnt != 4'h0);
    next_st.rx_rst = (next_st.rx_cnt != 4'h0);

    // read data stand only in the cycle after the read strobe; a quiet port reads 0
    if (reg_rd_i && hit) begin
      next_st.rdata = word;
    end else begin
      next_st.rdata = '0;
    end

    // lfps duration filter, only meaningful while the link sits in U2
    // the first synchroniser flop feeds only the second one
    next_st.lfps_sync = {st.lfps_sync[0], lfps_detect_i};
    next_st.u2_exit   = 1'b0;
    // a break in the burst or leaving U2 starts the measurement again
    if (!in_u2_i || !st.lfps_sync[1]) begin
      next_st.lfps_cnt = '0;
    // the count stops at the threshold, so one long burst gives one pulse
    end else if (st.lfps_cnt < lfps_thr) begin
      next_st.lfps_cnt = st.lfps_cnt + LFPS_CNT_W'(1);
      if ((st.lfps_cnt + LFPS_CNT_W'(1)) == lfps_thr) begin
        next_st.u2_exit = 1'b1;
      end
    end

    // remote exit handshake
    next_st.hs_done = 1'b0;
    unique case (st.hs)
      HS_IDLE: begin
        if (remote_exit_start_i) begin
          if (st.overlap) begin
            next_st.hs = HS_WAIT;
          end else begin
            // check off: the remote exit is taken on trust
            next_st.hs_done = 1'b1;
          end
        end
      end
      HS_WAIT: begin
        // a lone local glitch never completes the exit: the partner must answer
        if (partner_lfps_i || training_seen_i) begin
          next_st.hs      = HS_IDLE;
          next_st.hs_done = 1'b1;
        end
      end
      default: begin
        next_st.hs = HS_IDLE;
      end
    endcase

    // sleep towards the phy only while software allows it and the link asks for it
    next_st.utmi_sleep = st.l1_sleep & l1_sleep_req_i;

    // one reply strobe per token that finds the receive fifo empty
    next_st.send_zlp = 1'b0;
    next_st.send_nak = 1'b0;
    if (in_token_i && rx_fifo_empty_i) begin
      if (st.empty_nak) begin
        next_st.send_nak = 1'b1;
      end else begin
        next_st.send_zlp = 1'b1;
      end
    end
  end

  // the system reset ignores reset protection; only usb and lite resets honour it
  // ce_i low holds every flop, but the system reset still acts
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      // software-visible fields
      st.speed         <= SPEED_RESET;
      st.overlap       <= OVERLAP_FALLBACK;
      st.short_u2      <= SHORT_U2_FALLBACK;
      st.l1_sleep      <= L1_SLEEP_FALLBACK;
      st.empty_nak     <= EMPTY_REPLY_RESET;
      // image defaults fall back to the built-in values
      st.overlap_dflt  <= OVERLAP_FALLBACK;
      st.short_u2_dflt <= SHORT_U2_FALLBACK;
      st.l1_sleep_dflt <= L1_SLEEP_FALLBACK;
      // no sub-block reset runs
      st.tx_rst        <= SC_BIT_RESET;
      st.tx_cnt        <= 4'h0;
      st.rx_rst        <= SC_BIT_RESET;
      st.rx_cnt        <= 4'h0;
      // filter and handshake idle
      st.lfps_sync     <= 2'h0;
      st.lfps_cnt      <= '0;
      st.hs            <= HS_IDLE;
      st.hs_done       <= 1'b0;
      // output strobes quiet
      st.u2_exit       <= 1'b0;
      st.utmi_sleep    <= 1'b0;
      st.send_zlp      <= 1'b0;
      st.send_nak      <= 1'b0;
      st.rdata         <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // every output is a plain copy of a state flop
  assign reg_rdata_o                 = st.rdata;
  assign exit_handshake_done_o       = st.hs_done;
  assign u2_exit_o                   = st.u2_exit;
  assign bulk_in_transmitter_reset_o = st.tx_rst;
  assign bulk_out_receiver_reset_o   = st.rx_rst;
  assign utmi_sleep_o                = st.utmi_sleep;
  assign send_zlp_o                  = st.send_zlp;
  assign send_nak_o                  = st.send_nak;
  assign connect_speed_select_o      = st.speed;

endmodule

`default_nettype wire

// file: dv/ulc_props_properties.sv
// port assertions for the configuration fields block
`timescale 1ns/10ps
`default_nettype none
module ulc_props (
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        ce_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        remote_exit_start_i,
  input wire logic        partner_lfps_i,
  input wire logic        training_seen_i,
  input wire logic        exit_handshake_done_o,
  input wire logic        u2_exit_o,
  input wire logic        bulk_in_transmitter_reset_o,
  input wire logic        bulk_out_receiver_reset_o,
  input wire logic        l1_sleep_req_i,
  input wire logic        utmi_sleep_o,
  input wire logic        in_token_i,
  input wire logic        rx_fifo_empty_i,
  input wire logic        send_zlp_o,
  input wire logic        send_nak_o
);
  // a frozen clock enable holds every flop, so nothing is judged then
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i || !ce_i);
  sequence tx_req;
    reg_wr_i && reg_addr_i == 8'h80 && reg_wdata_i[10];
  endsequence
  sequence rx_req;
    reg_wr_i && reg_addr_i == 8'h80 && reg_wdata_i[9];
  endsequence
  tx_reset_len_a: assert property (tx_req |=> bulk_in_transmitter_reset_o[*4])
    else $error("transmitter reset pulse too short");
  rx_reset_len_a: assert property (rx_req |=> bulk_out_receiver_reset_o[*4])
    else $error("receiver reset pulse too short");
  zero_write_a: assert property (reg_wr_i && !reg_wdata_i[10] && !bulk_in_transmitter_reset_o
    |=> !bulk_in_transmitter_reset_o) else $error("zero write started a reset");
  done_cause_a: assert property (exit_handshake_done_o
    |-> $past(remote_exit_start_i || partner_lfps_i || training_seen_i)) else $error("done without cause");
  u2_single_a: assert property (u2_exit_o |=> !u2_exit_o)
    else $error("u2 exit pulse repeated");
  sleep_cause_a: assert property (utmi_sleep_o |-> $past(l1_sleep_req_i))
    else $error("sleep without request");
  reply_one_a: assert property (in_token_i && rx_fifo_empty_i |=> send_zlp_o ^ send_nak_o)
    else $error("empty reply not exactly one");
  reply_cause_a: assert property (send_zlp_o || send_nak_o
    |-> $past(in_token_i && rx_fifo_empty_i)) else $error("reply without token");
endmodule
bind ulc_config_fields ulc_props props (.*);
`default_nettype wire

// file: dv/ulc_host_model.sv
// host side of the link: lfps bursts and exit handshake answers
`timescale 1ns/10ps
`default_nettype none
module ulc_host_model (
  input  wire logic core_clk_i,
  output logic      lfps_o,
  output logic      partner_lfps_o,
  output logic      training_o
);
  initial begin
    lfps_o = 1'h0;
    partner_lfps_o = 1'h0;
    training_o = 1'h0;
  end
  // the detector pin is asynchronous, so edges land off the clock grid
  task automatic burst(input int n);
    #7 lfps_o = 1'h1;
    repeat (n) @(posedge core_clk_i);
    #7 lfps_o = 1'h0;
    @(posedge core_clk_i);
  endtask
  task automatic answer(input bit use_ts);
    if (use_ts) training_o <= 1'h1;
    else partner_lfps_o <= 1'h1;
    @(posedge core_clk_i);
    training_o <= 1'h0;
    partner_lfps_o <= 1'h0;
    @(posedge core_clk_i);
  endtask
endmodule
`default_nettype wire

// file: dv/usb_link_config_fields_tb.sv
// self-checking bench for the usb link configuration fields
`timescale 1ns/10ps
`default_nettype none
module usb_link_config_fields_tb;
  import ulc_pkg::*;
  logic core_clk_i = 0, sys_rst_i = 1, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0, image_load_i = 0;
  logic eeprom_present_i = 0, otp_present_i = 0, usb_reset_i = 0, lite_soft_reset_i = 0;
  logic rst_protect_i = 0, remote_exit_start_i = 0, in_u2_i = 0, l1_sleep_req_i = 0;
  logic in_token_i = 0, rx_fifo_empty_i = 0, exit_handshake_done_o, u2_exit_o, utmi_sleep_o;
  logic bulk_in_transmitter_reset_o, bulk_out_receiver_reset_o, send_zlp_o, send_nak_o;
  logic [2:0]  eeprom_flags_i = 0, otp_flags_i = 0, connect_speed_select_o;
  logic [7:0]  reg_addr_i = 0;
  logic [31:0] reg_wdata_i = 0, reg_rdata_o;
  wire logic   partner_lfps_i, training_seen_i, lfps_detect_i;
  int          miscompares = 0, tests_run = 0, n_done = 0, n_u2 = 0, cyc = 0;
  logic [2:0]  sp [3] = '{SPEED_SUPER, SPEED_HIGH, SPEED_FULL};
  ulc_config_fields dut (.*);
  ulc_host_model host (.core_clk_i(core_clk_i), .lfps_o(lfps_detect_i),
    .partner_lfps_o(partner_lfps_i), .training_o(training_seen_i));
  always #12.5 core_clk_i = ~core_clk_i;
  // count on the falling edge, so a check made at a rising edge sees pulses already counted
  always @(negedge core_clk_i) begin
    n_done <= n_done + exit_handshake_done_o;
    n_u2 <= n_u2 + u2_exit_o;
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    step(1);
    reg_wr_i <= 1'h0;
    step(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    step(1);
    reg_rd_i <= 1'h0;
    #1 chk("word", exp, reg_rdata_o);
    step(1);
  endtask
  // pulse codes: 0 remote exit start, 1 usb reset, 2 lite reset, 3 image load
  task automatic drive_pulse(input int k, input logic v);
    case (k)
      0: remote_exit_start_i <= v;
      1: usb_reset_i <= v;
      2: lite_soft_reset_i <= v;
      default: image_load_i <= v;
    endcase
  endtask
  task automatic pulse_in(input int k);
    drive_pulse(k, 1'h1);
    step(1);
    drive_pulse(k, 1'h0);
    step(1);
  endtask
  task automatic t_regs();
    rd(8'h80, 32'h8100);
    wr(8'h84, 32'hffffffff);
    rd(8'h84, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(8'h80, {16'h0, sp[i], 13'h0100});
      rd(8'h80, {16'h0, sp[i], 13'h0100});
      chk("speed", sp[i], connect_speed_select_o);
    end
    $display("test registers done");
  endtask
  task automatic t_subrst();
    for (int i = 9; i < 11; i++) begin
      wr(8'h80, 32'h8100);
      chk("idle", 0, {bulk_in_transmitter_reset_o, bulk_out_receiver_reset_o});
      wr(8'h80, 32'h8100 | (32'h1 << i));
      rd(8'h80, 32'h8100 | (32'h1 << i));
      step(2);
      rd(8'h80, 32'h8100);
    end
    $display("test sub-block resets done");
  endtask
  task automatic t_exit();
    wr(8'h80, 32'h8100);
    pulse_in(0);
    chk("done", 1, n_done);
    wr(8'h80, 32'h9100);
    pulse_in(0);
    step(6);
    chk("done", 1, n_done);
    host.answer(0);
    chk("done", 2, n_done);
    pulse_in(0);
    host.answer(1);
    chk("done", 3, n_done);
    in_u2_i <= 1'h1;
    wr(8'h80, 32'h8900);
    host.burst(9);
    step(6);
    chk("u2 exit", 0, n_u2);
    host.burst(12);
    step(6);
    chk("u2 exit", 1, n_u2);
    wr(8'h80, 32'h8100);
    host.burst(160);
    step(6);
    chk("u2 exit", 1, n_u2);
    host.burst(330);
    step(6);
    chk("u2 exit", 2, n_u2);
    in_u2_i <= 1'h0;
    $display("test link exits done");
  endtask
  task automatic t_replies();
    rx_fifo_empty_i <= 1'h1;
    for (int b = 0; b < 2; b++) begin
      wr(8'h80, 32'h8000 | (b << 6) | (b << 8));
      in_token_i <= 1'h1;
      l1_sleep_req_i <= 1'h1;
      step(1);
      in_token_i <= 1'h0;
      #1 chk("reply", b ? 2 : 1, {send_nak_o, send_zlp_o});
      step(2);
      chk("sleep", b, utmi_sleep_o);
      l1_sleep_req_i <= 1'h0;
    end
    rx_fifo_empty_i <= 1'h0;
    in_token_i <= 1'h1;
    step(1);
    in_token_i <= 1'h0;
    #1 chk("reply", 0, {send_nak_o, send_zlp_o});
    step(1);
    $display("test replies done");
  endtask
  task automatic t_defaults();
    wr(8'h80, 32'h3140);
    rst_protect_i <= 1'h1;
    pulse_in(1);
    rd(8'h80, 32'h3100);
    rst_protect_i <= 1'h0;
    pulse_in(2);
    rd(8'h80, 32'h8100);
    eeprom_present_i <= 1'h1;
    eeprom_flags_i <= 3'h3;
    otp_flags_i <= 3'h6;
    pulse_in(3);
    wr(8'h80, 32'h8100);
    pulse_in(1);
    rd(8'h80, 32'h9800);
    eeprom_present_i <= 1'h0;
    otp_present_i <= 1'h1;
    pulse_in(3);
    rd(8'h80, 32'h8900);
    otp_present_i <= 1'h0;
    pulse_in(3);
    rd(8'h80, 32'h8100);
    $display("test defaults done");
  endtask
  task automatic t_freeze();
    ce_i <= 1'h0;
    wr(8'h80, 32'h2500);
    chk("frozen", 32'h4, {bulk_in_transmitter_reset_o, connect_speed_select_o});
    ce_i <= 1'h1;
    rd(8'h80, 32'h8100);
    rst_protect_i <= 1'h1;
    wr(8'h80, 32'h2000);
    sys_rst_i <= 1'h1;
    step(2);
    sys_rst_i <= 1'h0;
    rst_protect_i <= 1'h0;
    rd(8'h80, 32'h8100);
    $display("test clock enable and mid-run reset done");
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    step(2);
    sys_rst_i <= 1'h0;
    step(1);
    t_regs();
    t_subrst();
    t_exit();
    t_replies();
    t_defaults();
    t_freeze();
    final_report();
  end
endmodule
`default_nettype wire
